// ---- pkg/qpsp_pkg.sv ----
package qpsp_pkg;

    // Clock and times
    localparam int CLOCK_PERIOD_NS             = 4;
    localparam int GLITCH_FILTER_SPAN_NS       = 200;
    localparam int GLITCH_CYCLES               = (GLITCH_FILTER_SPAN_NS / CLOCK_PERIOD_NS < 1) ? 1
                                                 : GLITCH_FILTER_SPAN_NS / CLOCK_PERIOD_NS;
    localparam int WIPER_SETTLE_DELAY_US       = 5;
    localparam int WIPER_SETTLE_CYCLES         = (WIPER_SETTLE_DELAY_US * 1000
                                                  + CLOCK_PERIOD_NS - 1)
                                                 / CLOCK_PERIOD_NS;
    localparam int NONVOLATILE_PROGRAM_TIME_MS = 5;
    localparam int PROGRAM_CYCLES              = NONVOLATILE_PROGRAM_TIME_MS * 1000000
                                                 / CLOCK_PERIOD_NS;

    // Slave address; value is arbitrary
    localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;

    // Instruction opcodes
    localparam logic [3:0] OP_READ_WIPER    = 4'h9;
    localparam logic [3:0] OP_WRITE_WIPER   = 4'hA;
    localparam logic [3:0] OP_READ_SETTING  = 4'hB;
    localparam logic [3:0] OP_WRITE_SETTING = 4'hC;

    // Instruction byte fields
    localparam int OPCODE_LSB  = 4;
    localparam int SETTING_LSB = 2;
    localparam int POT_LSB     = 0;

    // Bit counter marks
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK_DRIVE = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE  = 4'h9;

    // Values after reset
    localparam logic [7:0] SETTING_RESET = 8'h80;
    localparam logic [7:0] WIPER_RESET   = 8'h00;
    localparam logic [1:0] POWER_ON_SETTING_SLOT = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INSTR,
        ST_WDATA,
        ST_RDATA,
        ST_WAITSTOP
    } qpsp_state_t;

    typedef enum logic {
        CMD_WIPER,
        CMD_PROGRAM
    } qpsp_cmd_t;

    function automatic logic [3:0] qpsp_slot(input logic [1:0] pot, input logic [1:0] sel);
        return {pot, sel};
    endfunction

endpackage

// ---- pkg/qpsp_store_if.sv ----
interface qpsp_store_if;
    import qpsp_pkg::*;

    logic            cmdValid;
    qpsp_cmd_t       cmdKind;
    logic [1:0]      potSel;
    logic [1:0]      settingSel;
    logic [7:0]      cmdData;
    logic [7:0]      wiperRead;
    logic [7:0]      settingRead;
    logic [3:0][7:0] wiperAll;
    logic            busy;

    modport ctrl (
        output cmdValid, cmdKind, potSel, settingSel, cmdData,
        input  wiperRead, settingRead, wiperAll, busy
    );

    modport store (
        input  cmdValid, cmdKind, potSel, settingSel, cmdData,
        output wiperRead, settingRead, wiperAll, busy
    );
endinterface

// ---- logic/qpsp_line_filter.sv ----
module qpsp_line_filter
    import qpsp_pkg::*;
#(
    parameter int SPAN = GLITCH_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic enable,
    // Line
    input  wire logic lineIn,
    output logic      lineOut
);
    localparam int CW = $clog2(SPAN + 1);

    logic          meta;
    logic          stable;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_lineOut;

    // Idle bus level is high
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta    <= 1'b1;
            stable  <= 1'b1;
            count   <= '0;
            lineOut <= 1'b1;
        end else if (enable) begin
            meta    <= lineIn;
            stable  <= meta;
            count   <= next_count;
            lineOut <= next_lineOut;
        end
    end

    // Level must hold for the whole span before it is passed on
    always_comb begin
        next_count   = count;
        next_lineOut = lineOut;
        if (stable == lineOut) begin
            next_count = '0;
        end else if (count == CW'(SPAN - 1)) begin
            next_count   = '0;
            next_lineOut = stable;
        end else begin
            next_count = count + CW'(1);
        end
    end
endmodule

// ---- logic/qpsp_setting_store.sv ----
module qpsp_setting_store
    import qpsp_pkg::*;
#(
    parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES,
    parameter int SETTLE_CYCLES_P  = WIPER_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   reset_n,
    input  wire logic   enable,
    // Command side
    qpsp_store_if.store bus
);
    localparam int PW = $clog2(PROGRAM_CYCLES_P + 1);
    localparam int SW = $clog2(SETTLE_CYCLES_P + 1);

    logic [7:0]      settings [16];
    logic [7:0]      next_settings [16];
    logic [3:0][7:0] wiper;
    logic [3:0][7:0] next_wiper;
    logic            loadPending, next_loadPending;
    logic            wiperPend, next_wiperPend;
    logic [1:0]      wiperPot, next_wiperPot;
    logic [7:0]      wiperTarget, next_wiperTarget;
    logic [SW-1:0]   settleCnt, next_settleCnt;
    logic            progActive, next_progActive;
    logic [3:0]      progSlot, next_progSlot;
    logic [7:0]      progData, next_progData;
    logic [PW-1:0]   progCnt, next_progCnt;

    assign bus.wiperAll    = wiper;
    assign bus.wiperRead   = wiper[bus.potSel];
    assign bus.settingRead = settings[qpsp_slot(bus.potSel, bus.settingSel)];
    assign bus.busy        = progActive;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) settings[i] <= SETTING_RESET;
            wiper       <= {4{WIPER_RESET}};
            loadPending <= 1'b1;
            wiperPend   <= 1'b0;
            wiperPot    <= 2'h0;
            wiperTarget <= 8'h00;
            settleCnt   <= '0;
            progActive  <= 1'b0;
            progSlot    <= 4'h0;
            progData    <= 8'h00;
            progCnt     <= '0;
        end else if (enable) begin
            settings    <= next_settings;
            wiper       <= next_wiper;
            loadPending <= next_loadPending;
            wiperPend   <= next_wiperPend;
            wiperPot    <= next_wiperPot;
            wiperTarget <= next_wiperTarget;
            settleCnt   <= next_settleCnt;
            progActive  <= next_progActive;
            progSlot    <= next_progSlot;
            progData    <= next_progData;
            progCnt     <= next_progCnt;
        end
    end

    always_comb begin
        next_settings    = settings;
        next_wiper       = wiper;
        next_loadPending = 1'b0;
        next_wiperPend   = wiperPend;
        next_wiperPot    = wiperPot;
        next_wiperTarget = wiperTarget;
        next_settleCnt   = settleCnt;
        next_progActive  = progActive;
        next_progSlot    = progSlot;
        next_progData    = progData;
        next_progCnt     = progCnt;
        // First enabled cycle after reset recalls the stored setting
        if (loadPending) begin
            for (int p = 0; p < 4; p++) begin
                next_wiper[p] = settings[qpsp_slot(2'(p), POWER_ON_SETTING_SLOT)];
            end
        end
        if (wiperPend) begin
            if (settleCnt == SW'(SETTLE_CYCLES_P - 1)) begin
                next_wiper[wiperPot] = wiperTarget;
                next_wiperPend       = 1'b0;
            end else begin
                next_settleCnt = settleCnt + SW'(1);
            end
        end
        if (progActive) begin
            if (progCnt == PW'(PROGRAM_CYCLES_P - 1)) begin
                next_settings[progSlot] = progData;
                next_progActive         = 1'b0;
            end else begin
                next_progCnt = progCnt + PW'(1);
            end
        end
        // A new wiper write restarts the settle delay
        if (bus.cmdValid && bus.cmdKind == CMD_WIPER) begin
            next_wiperPend   = 1'b1;
            next_wiperPot    = bus.potSel;
            next_wiperTarget = bus.cmdData;
            next_settleCnt   = '0;
        end
        if (bus.cmdValid && bus.cmdKind == CMD_PROGRAM && !progActive) begin
            next_progActive = 1'b1;
            next_progSlot   = qpsp_slot(bus.potSel, bus.settingSel);
            next_progData   = bus.cmdData;
            next_progCnt    = '0;
        end
    end
endmodule

// ---- logic/qpsp_serial_slave.sv ----
// Operation
// - START is data falling while clock high; nothing is answered before one.
// - STOP is data rising while clock high.
// - Data steady while clock high; any change there is START or STOP.
// - Master makes the clock; this port is slave only, never drives it.
// - Address is type code in upper four bits, strap pins below.
// - Address byte is acknowledged only on a full match with the straps.
// - Receiver pulls data low on the ninth clock to acknowledge.
// - Every byte of a selected write is acknowledged, except stored setting data bytes while the protect pin is low.
// - Instruction byte is opcode, then setting select, then pot select.
// - Stored setting write begins programming at the closing STOP.
// - While programming, data line stays released and nothing is acknowledged.
// - Programming finishes within the programming time after the STOP.
// - Read shifts out eight bits, releases, samples master ack, repeats.
// - Without a master ack the port stops sending and waits for STOP.
// - Wiper moves after the settle delay following a wiper write.
// - Clock and data inputs are glitch filtered.
// - Polling address gets no ack while busy, an ack once done.
// - Protect pin low refuses stored setting data bytes.
// - At power-up each wiper loads from its first stored setting.
module qpsp_serial_slave
    import qpsp_pkg::*;
#(
    parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        enable,
    // Serial bus pins
    input  wire logic        serialClock,
    input  wire logic        serialDataIn,
    output logic             serialDataOut,
    output logic             serialDataOe,
    // Address straps and protection
    input  wire logic        addressStrapBit0,
    input  wire logic        addressStrapBit1,
    input  wire logic        addressStrapBit2,
    input  wire logic        addressStrapBit3,
    input  wire logic        writeProtect_n,
    // Potentiometer state
    output logic [3:0][7:0]  wiperPosition,
    output logic             programBusy
);
    qpsp_store_if bus ();

    logic        sclF;
    logic        sdaF;
    logic        sclPrev;
    logic        sdaPrev;
    logic [4:0]  pinMeta;
    logic [4:0]  pinSync;
    logic [3:0]  strap;
    logic        wpHigh;

    qpsp_state_t state, next_state;
    logic [3:0]  bitCnt, next_bitCnt;
    logic [7:0]  shiftIn, next_shiftIn;
    logic [7:0]  txShift, next_txShift;
    logic        sdaDrive, next_sdaDrive;
    logic [3:0]  opcode, next_opcode;
    logic [1:0]  settingSel, next_settingSel;
    logic [1:0]  potSel, next_potSel;
    logic        firstData, next_firstData;
    logic        progPending, next_progPending;
    logic        masterAck, next_masterAck;
    logic        cmdValid, next_cmdValid;
    qpsp_cmd_t   cmdKind, next_cmdKind;
    logic [7:0]  cmdData, next_cmdData;

    logic        sclRise, sclFall, sdaRise, sdaFall;
    logic [7:0]  readByte;

    qpsp_line_filter #(.SPAN(GLITCH_CYCLES)) u_scl_filter (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .lineIn  (serialClock),
        .lineOut (sclF)
    );

    qpsp_line_filter #(.SPAN(GLITCH_CYCLES)) u_sda_filter (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .lineIn  (serialDataIn),
        .lineOut (sdaF)
    );

    qpsp_setting_store #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)) u_store (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .bus     (bus.store)
    );

    // Straps may be driven live, so they are resampled every cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (enable) begin
            pinMeta <= {writeProtect_n, addressStrapBit3, addressStrapBit2,
                        addressStrapBit1, addressStrapBit0};
            pinSync <= pinMeta;
            sclPrev <= sclF;
            sdaPrev <= sdaF;
        end
    end

    assign strap   = pinSync[3:0];
    assign wpHigh  = pinSync[4];
    assign sclRise = sclF & ~sclPrev;
    assign sclFall = ~sclF & sclPrev;
    assign sdaRise = sdaF & ~sdaPrev;
    assign sdaFall = ~sdaF & sdaPrev;

    assign readByte = (opcode == OP_READ_WIPER) ? bus.wiperRead : bus.settingRead;

    assign bus.cmdValid   = cmdValid;
    assign bus.cmdKind    = cmdKind;
    assign bus.potSel     = potSel;
    assign bus.settingSel = settingSel;
    assign bus.cmdData    = cmdData;

    // Open drain: only ever pulls low, clock is never driven
    assign serialDataOut = 1'b0;
    assign serialDataOe  = sdaDrive;
    assign wiperPosition = bus.wiperAll;
    assign programBusy   = bus.busy;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state       <= ST_IDLE;
            bitCnt      <= 4'h0;
            shiftIn     <= 8'h00;
            txShift     <= 8'h00;
            sdaDrive    <= 1'b0;
            opcode      <= 4'h0;
            settingSel  <= 2'h0;
            potSel      <= 2'h0;
            firstData   <= 1'b0;
            progPending <= 1'b0;
            masterAck   <= 1'b0;
            cmdValid    <= 1'b0;
            cmdKind     <= CMD_WIPER;
            cmdData     <= 8'h00;
        end else if (enable) begin
            state       <= next_state;
            bitCnt      <= next_bitCnt;
            shiftIn     <= next_shiftIn;
            txShift     <= next_txShift;
            sdaDrive    <= next_sdaDrive;
            opcode      <= next_opcode;
            settingSel  <= next_settingSel;
            potSel      <= next_potSel;
            firstData   <= next_firstData;
            progPending <= next_progPending;
            masterAck   <= next_masterAck;
            cmdValid    <= next_cmdValid;
            cmdKind     <= next_cmdKind;
            cmdData     <= next_cmdData;
        end
    end

    always_comb begin
        next_state       = state;
        next_bitCnt      = bitCnt;
        next_shiftIn     = shiftIn;
        next_txShift     = txShift;
        next_sdaDrive    = sdaDrive;
        next_opcode      = opcode;
        next_settingSel  = settingSel;
        next_potSel      = potSel;
        next_firstData   = firstData;
        next_progPending = progPending;
        next_masterAck   = masterAck;
        next_cmdValid    = 1'b0;
        next_cmdKind     = cmdKind;
        next_cmdData     = cmdData;
        if (sclF && sdaFall) begin
            // Busy programming: START is ignored, so polling gets no ack
            next_bitCnt      = 4'h0;
            next_sdaDrive    = 1'b0;
            next_progPending = 1'b0;
            next_state       = bus.busy ? ST_IDLE : ST_ADDR;
        end else if (sclF && sdaRise) begin
            // Protect pin dropping before the STOP cancels the program
            if (progPending && wpHigh) begin
                next_cmdValid = 1'b1;
                next_cmdKind  = CMD_PROGRAM;
            end
            next_progPending = 1'b0;
            next_sdaDrive    = 1'b0;
            next_state       = ST_IDLE;
        end else if (sclRise) begin
            case (state)
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    if (bitCnt <= BIT_LAST_DATA) begin
                        next_shiftIn = {shiftIn[6:0], sdaF};
                    end
                    next_bitCnt = bitCnt + 4'h1;
                end
                ST_RDATA: begin
                    if (bitCnt == BIT_ACK_DRIVE) begin
                        next_masterAck = ~sdaF;
                    end
                    next_bitCnt = bitCnt + 4'h1;
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (state)
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    if (bitCnt == BIT_ACK_DRIVE) begin
                        next_sdaDrive = 1'b1;
                        if (state == ST_ADDR) begin
                            if (shiftIn != {DEVICE_TYPE_CODE, strap}) begin
                                next_sdaDrive = 1'b0;
                                next_state    = ST_IDLE;
                            end
                        end else if (state == ST_INSTR) begin
                            next_opcode     = shiftIn[OPCODE_LSB +: 4];
                            next_settingSel = shiftIn[SETTING_LSB +: 2];
                            next_potSel     = shiftIn[POT_LSB +: 2];
                        end else if (firstData && opcode == OP_WRITE_SETTING && !wpHigh) begin
                            next_sdaDrive = 1'b0;
                            next_state    = ST_WAITSTOP;
                        end else begin
                            // Bytes after the first are acked and dropped
                            next_firstData = 1'b0;
                            if (firstData && opcode == OP_WRITE_WIPER) begin
                                next_cmdValid = 1'b1;
                                next_cmdKind  = CMD_WIPER;
                                next_cmdData  = shiftIn;
                            end else if (firstData && opcode == OP_WRITE_SETTING) begin
                                next_progPending = 1'b1;
                                next_cmdData     = shiftIn;
                            end
                        end
                    end else if (bitCnt == BIT_ACK_DONE) begin
                        next_sdaDrive = 1'b0;
                        next_bitCnt   = 4'h0;
                        if (state == ST_ADDR) begin
                            next_state = ST_INSTR;
                        end else if (state == ST_INSTR) begin
                            if (opcode == OP_READ_WIPER || opcode == OP_READ_SETTING) begin
                                next_state    = ST_RDATA;
                                next_txShift  = readByte;
                                next_sdaDrive = ~readByte[7];
                            end else begin
                                next_state     = ST_WDATA;
                                next_firstData = 1'b1;
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (bitCnt < BIT_ACK_DRIVE) begin
                        next_txShift  = {txShift[6:0], 1'b0};
                        next_sdaDrive = ~txShift[6];
                    end else if (bitCnt == BIT_ACK_DRIVE) begin
                        next_sdaDrive = 1'b0;
                    end else begin
                        next_bitCnt = 4'h0;
                        if (masterAck) begin
                            next_txShift  = readByte;
                            next_sdaDrive = ~readByte[7];
                        end else begin
                            next_state = ST_WAITSTOP;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// ---- verification/qpsp_serial_slave_properties.sv ----
module qpsp_serial_slave_properties #(
    parameter int PROGRAM_CYCLES_P = 1
) (
    // Clock and reset
    input wire logic            clock,
    input wire logic            reset_n,
    input wire logic            enable,
    // Serial bus pins
    input wire logic            serialClock,
    input wire logic            serialDataIn,
    input wire logic            serialDataOut,
    input wire logic            serialDataOe,
    // Straps and protection
    input wire logic            addressStrapBit0,
    input wire logic            addressStrapBit1,
    input wire logic            addressStrapBit2,
    input wire logic            addressStrapBit3,
    input wire logic            writeProtect_n,
    // Potentiometer state
    input wire logic [3:0][7:0] wiperPosition,
    input wire logic            programBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    int busyCount;
    int next_busyCount;
    always_comb next_busyCount = programBusy ? busyCount + 1 : 0;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) busyCount <= 0;
        else busyCount <= next_busyCount;
    end
    // Open drain: only ever pulls low
    property p_pull_low; serialDataOut == 1'b0; endproperty
    a_pull_low: assert property (p_pull_low) else $error("data driven high");
    property p_busy_quiet; programBusy |-> !serialDataOe; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
    property p_oe_rise_low; $rose(serialDataOe) |-> !serialClock; endproperty
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("pull at clock high");
    property p_oe_fall_low; $fell(serialDataOe) |-> !serialClock; endproperty
    a_oe_fall_low: assert property (p_oe_fall_low) else $error("release at clock high");
    property p_ack_hold; $rose(serialDataOe) |=> serialDataOe [*8]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("pull too short");
    property p_busy_on_stop; $rose(programBusy) |-> serialClock && serialDataIn; endproperty
    a_busy_on_stop: assert property (p_busy_on_stop) else $error("busy not after stop");
    property p_busy_min; $rose(programBusy) |=> programBusy [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy glitch");
    property p_busy_max; busyCount <= PROGRAM_CYCLES_P; endproperty
    a_busy_max: assert property (p_busy_max) else $error("programming too long");
    cover property ($rose(serialDataOe));
    cover property ($fell(programBusy));
    cover property (serialDataOe && wiperPosition[2] == 8'h5A);
endmodule

// ---- verification/qpsp_bus_master.sv ----
module qpsp_bus_master #(
    parameter int H = 70
) (
    // Clock
    input wire logic clock,
    // Bus lines
    input wire logic dataOe,
    output logic     serialClock,
    output logic     busLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drive;
    // Pull-up: a released line reads high
    assign busLevel = drive & ~dataOe;
    initial begin
        serialClock = 1'b1;
        drive = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        @(posedge clock);
        serialClock <= c;
        drive <= d;
        repeat (H - 1) @(posedge clock);
    endtask
    // Clock goes low before data moves, so no false edge
    task automatic start();
        step(1'b0, drive);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    // Low pulse on data, shorter than the filter span, clock high
    task automatic glitch(input int n);
        @(posedge clock);
        drive <= 1'b0;
        repeat (n) @(posedge clock);
        drive <= 1'b1;
        repeat (H - 1) @(posedge clock);
    endtask
    task automatic stop();
        step(1'b0, drive);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Eight bits then the ack slot, MSB first
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, drive);
            step(1'b0, tx[i]);
            step(1'b1, tx[i]);
            rx[i] = busLevel;
        end
    endtask
endmodule

// ---- verification/testbench.sv ----
module testbench import qpsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 6000;
    localparam logic [3:0] STRAP = 4'h6;
    localparam logic [7:0] ADDR = {DEVICE_TYPE_CODE, STRAP};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic writeProtect_n = 1'b1;
    logic [3:0] strap = STRAP;
    logic sClk, sData, dataOe, busy;
    logic [3:0][7:0] wipers;
    int fails = 0;
    int nChecks = 0;
    int cycles = 0;
    always #2 clock = ~clock;
    qpsp_serial_slave #(.PROGRAM_CYCLES_P(PROG)) qpsp_serial_slave_i (.clock(clock),
        .reset_n(reset_n), .enable(1'b1), .serialClock(sClk), .serialDataIn(sData),
        .serialDataOut(), .serialDataOe(dataOe), .addressStrapBit0(strap[0]),
        .addressStrapBit1(strap[1]), .addressStrapBit2(strap[2]),
        .addressStrapBit3(strap[3]), .writeProtect_n(writeProtect_n),
        .wiperPosition(wipers), .programBusy(busy));
    qpsp_bus_master qpsp_bus_master_i (.clock(clock), .dataOe(dataOe),
        .serialClock(sClk), .busLevel(sData));
    task automatic report_and_stop();
        if (fails == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        // Whole run needs about 55k cycles
        if (cycles == 80000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b, input logic ack);
        logic [8:0] rx;
        qpsp_bus_master_i.xfer({b, 1'b1}, rx);
        chk(32'(rx[0]), 32'(ack));
    endtask
    task automatic rd(input logic [7:0] exp, input logic masterAck);
        logic [8:0] rx;
        qpsp_bus_master_i.xfer({8'hFF, masterAck}, rx);
        chk(32'(rx[8:1]), 32'(exp));
    endtask
    task automatic rdback(input logic [7:0] instr, input logic [7:0] exp);
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b0);
        wr(instr, 1'b0);
        rd(exp, 1'b1);
        qpsp_bus_master_i.stop();
    endtask
    task automatic t_mismatch();
        // A filtered pulse is no START, so the address goes unanswered
        qpsp_bus_master_i.glitch(40);
        wr(ADDR, 1'b1);
        qpsp_bus_master_i.stop();
        qpsp_bus_master_i.start();
        wr({DEVICE_TYPE_CODE, ~STRAP}, 1'b1);
        wr(8'hA0, 1'b1);
        qpsp_bus_master_i.stop();
    endtask
    task automatic t_wiper();
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b0);
        wr({OP_WRITE_WIPER, 2'h0, 2'h2}, 1'b0);
        wr(8'h5A, 1'b0);
        qpsp_bus_master_i.stop();
        repeat (1300) @(posedge clock);
        chk(32'(wipers[2]), 32'h5A);
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b0);
        wr({OP_READ_WIPER, 2'h0, 2'h2}, 1'b0);
        rd(8'h5A, 1'b0);
        rd(8'h5A, 1'b1);
        rd(8'hFF, 1'b1);
        qpsp_bus_master_i.stop();
    endtask
    task automatic t_setting();
        int n;
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b0);
        wr({OP_WRITE_SETTING, 2'h3, 2'h1}, 1'b0);
        wr(8'h3C, 1'b0);
        qpsp_bus_master_i.stop();
        chk(32'(busy), 32'h1);
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b1);
        qpsp_bus_master_i.stop();
        n = 0;
        while (busy === 1'b1 && n < PROG) begin
            @(posedge clock);
            n++;
        end
        chk(32'(busy), 32'h0);
        rdback({OP_READ_SETTING, 2'h3, 2'h1}, 8'h3C);
    endtask
    task automatic t_protect();
        @(posedge clock);
        writeProtect_n <= 1'b0;
        qpsp_bus_master_i.start();
        wr(ADDR, 1'b0);
        wr({OP_WRITE_SETTING, 2'h3, 2'h1}, 1'b0);
        wr(8'h11, 1'b1);
        qpsp_bus_master_i.stop();
        chk(32'(busy), 32'h0);
        writeProtect_n <= 1'b1;
        rdback({OP_READ_SETTING, 2'h3, 2'h1}, 8'h3C);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        // Let the line filters settle before the first frame
        repeat (100) @(posedge clock);
        chk(32'(wipers), {4{SETTING_RESET}});
        t_mismatch();
        t_wiper();
        t_setting();
        t_protect();
        report_and_stop();
    end
endmodule
bind qpsp_serial_slave qpsp_serial_slave_properties
    #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)) props_i (
    .clock(clock), .reset_n(reset_n), .enable(enable), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .addressStrapBit0(addressStrapBit0), .addressStrapBit1(addressStrapBit1),
    .addressStrapBit2(addressStrapBit2), .addressStrapBit3(addressStrapBit3),
    .writeProtect_n(writeProtect_n), .wiperPosition(wiperPosition), .programBusy(programBusy));
